//--- hw/tcrp_cfg.svh
// Notes on behaviour
// - First-group counter read returns live count.
// - Timer reload-cycle read returns all ones.
// - Event reload read: ones underflow, zeros overflow.
// - Halted write then read returns written value.
// - Entering pulse mode sets interrupt request.
// - Stop with pin high: pin low, request set.
// - Stop with pin low: no change, no request.
// - Second-group timer read: live, reload gives ones.
// - Second-group halted write reads back written value.
`ifndef TCRP_CFG_SVH
`define TCRP_CFG_SVH

`define TCRP_ADDR_W 6
`define TCRP_DATA_W 16
`define TCRP_CH_STRIDE 2
`define TCRP_OFS_CTRL 6'h00
`define TCRP_OFS_COUNT 6'h01
`define TCRP_ADDR_START 6'h20
`define TCRP_ADDR_STATUS 6'h21
`define TCRP_ADDR_MASK 6'h22
`define TCRP_CTRL_MODE_LSB 0
`define TCRP_CTRL_MODE_MSB 1
`define TCRP_CTRL_UP_BIT 2
`define TCRP_CTRL_FREE_BIT 3
`define TCRP_MODE_CODE_TIMER 2'h0
`define TCRP_MODE_CODE_EVENT 2'h1
`define TCRP_MODE_CODE_PWM 2'h2
`define TCRP_CTRL_RELOAD_BIT 4
`define TCRP_CTRL_PIN_BIT 5
`define TCRP_COUNT_RESET 16'hFFFF
`define TCRP_ALL_ONES 16'hFFFF
`define TCRP_ALL_ZEROS 16'h0000

`endif

//--- hw/tcrp_channel.sv
`timescale 1ns/1ps
`default_nettype none
`include "tcrp_cfg.svh"
module tcrp_channel (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic start,
    input wire tcrp_pkg::tcrp_mode_t mode,
    input wire logic count_up,
    input wire logic free_run,
    input wire logic wr_count,
    input wire logic [15:0] wr_data,
    input wire logic event_pulse,
    output logic [15:0] count,
    output logic reload_cycle,
    output logic pulse_out,
    output logic irq_event
);
    logic [15:0] count_reg;
    logic [15:0] count_next;
    logic [15:0] reload_reg;
    logic reload_pend_reg;
    logic start_prev_reg;
    tcrp_pkg::tcrp_mode_t mode_prev_reg;
    logic pulse_reg;
    logic irq_reg;

    wire is_event = (mode == tcrp_pkg::TCRP_MODE_EVENT);
    wire is_pwm = (mode == tcrp_pkg::TCRP_MODE_PWM);
    wire tick = start && (is_event ? event_pulse : 1'b1);
    wire going_up = is_event && count_up;
    wire wrap_dn = tick && !going_up && (count_reg == `TCRP_ALL_ZEROS);
    wire wrap_up = tick && going_up && (count_reg == `TCRP_ALL_ONES);
    wire do_reload = reload_pend_reg && !(is_event && free_run);
    wire enter_pwm = is_pwm && (mode_prev_reg != tcrp_pkg::TCRP_MODE_PWM);
    wire stop_pwm = is_pwm && start_prev_reg && !start;
    // While halted, or free running in event mode, a write goes to the counter directly.
    wire load_direct = wr_count && (!start || (is_event && free_run));

    always_comb begin
        count_next = count_reg;
        if (load_direct) begin
            count_next = wr_data;
        end else if (do_reload) begin
            count_next = reload_reg;
        end else if (tick) begin
            count_next = going_up ? count_reg + 16'h0001 : count_reg - 16'h0001;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            count_reg <= `TCRP_COUNT_RESET;
            reload_reg <= `TCRP_COUNT_RESET;
            reload_pend_reg <= 1'b0;
            start_prev_reg <= 1'b0;
            mode_prev_reg <= tcrp_pkg::TCRP_MODE_TIMER;
            pulse_reg <= 1'b0;
            irq_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            if (wr_count) begin
                reload_reg <= wr_data;
            end
            reload_pend_reg <= (wrap_dn || wrap_up) && !load_direct;
            start_prev_reg <= start;
            mode_prev_reg <= mode;
            if (!is_pwm || stop_pwm) begin
                pulse_reg <= 1'b0;
            end else if (start && !start_prev_reg) begin
                pulse_reg <= 1'b1;
            end else if (wrap_dn) begin
                pulse_reg <= !pulse_reg;
            end
            // request on entering pulse mode, on any wrap outside pulse mode, and in pulse mode only when the pin falls
            irq_reg <= enter_pwm || (stop_pwm && pulse_reg) || wrap_up
                || (wrap_dn && (!is_pwm || pulse_reg));
        end
    end

    // live count, the wrapped value marks the reload cycle
    assign count = count_reg;
    assign reload_cycle = reload_pend_reg;
    assign pulse_out = pulse_reg;
    assign irq_event = irq_reg;
endmodule
`default_nettype wire

//--- hw/tcrp_pkg.sv
package tcrp_pkg;
    typedef enum logic [2:0] {
        TCRP_MODE_TIMER = 3'h1,
        TCRP_MODE_EVENT = 3'h2,
        TCRP_MODE_PWM = 3'h4
    } tcrp_mode_t;
endpackage

//--- hw/tcrp_top.sv
// Implementation choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "tcrp_cfg.svh"
module tcrp_top #(
    parameter int NUM_FIRST = 2,
    parameter int NUM_SECOND = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [5:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic [NUM_FIRST+NUM_SECOND-1:0] event_in,
    output logic [NUM_FIRST+NUM_SECOND-1:0] pulse_output_pin,
    output logic irq
);
    localparam int NUM_CH = NUM_FIRST + NUM_SECOND;

    // The address map leaves room for sixteen channels below the shared registers.
    if (NUM_FIRST < 1 || NUM_CH > 16 || NUM_SECOND < 0) begin : gen_bad_count
        $error("tcrp_top: channel counts out of range");
    end

    // Channel index from an address; out of range means no channel.
    function automatic int chan_of(input logic [5:0] a);
        int idx;
        idx = int'(a) / `TCRP_CH_STRIDE;
        if (idx >= NUM_CH || a >= `TCRP_ADDR_START) begin
            idx = -1;
        end
        return idx;
    endfunction

    function automatic logic is_count_ofs(input logic [5:0] a);
        return (a % `TCRP_CH_STRIDE) == `TCRP_OFS_COUNT;
    endfunction

    function automatic tcrp_pkg::tcrp_mode_t decode_mode(input logic [1:0] code);
        tcrp_pkg::tcrp_mode_t m;
        case (code)
            `TCRP_MODE_CODE_TIMER: m = tcrp_pkg::TCRP_MODE_TIMER;
            `TCRP_MODE_CODE_EVENT: m = tcrp_pkg::TCRP_MODE_EVENT;
            default: m = tcrp_pkg::TCRP_MODE_PWM;
        endcase
        return m;
    endfunction

    function automatic logic [1:0] encode_mode(input tcrp_pkg::tcrp_mode_t m);
        logic [1:0] c;
        case (m)
            tcrp_pkg::TCRP_MODE_TIMER: c = `TCRP_MODE_CODE_TIMER;
            tcrp_pkg::TCRP_MODE_EVENT: c = `TCRP_MODE_CODE_EVENT;
            default: c = `TCRP_MODE_CODE_PWM;
        endcase
        return c;
    endfunction

    int wr_chan;
    assign wr_chan = chan_of(reg_addr);
    wire wr_is_count = is_count_ofs(reg_addr);
    wire wr_start = reg_wr && (reg_addr == `TCRP_ADDR_START);
    wire wr_status = reg_wr && (reg_addr == `TCRP_ADDR_STATUS);
    wire wr_mask = reg_wr && (reg_addr == `TCRP_ADDR_MASK);

    logic [NUM_CH-1:0] start_reg;
    logic [NUM_CH-1:0] status_reg;
    logic [NUM_CH-1:0] status_next;
    logic [NUM_CH-1:0] mask_reg;
    logic [NUM_CH-1:0] irq_evt;
    logic [NUM_CH-1:0] reload_cyc;
    logic [NUM_CH-1:0] up_reg;
    logic [NUM_CH-1:0] free_reg;
    logic [NUM_CH-1:0] pulse_w;
    logic [NUM_CH-1:0] sync1_reg;
    logic [NUM_CH-1:0] sync2_reg;
    logic [NUM_CH-1:0] sync3_reg;
    logic [NUM_CH-1:0] wr_count_sel;
    logic [15:0] count_w [NUM_CH];
    tcrp_pkg::tcrp_mode_t mode_reg [NUM_CH];
    logic [15:0] rdata_reg;
    logic [15:0] rdata_next;
    logic irq_reg;

    // The first stage only feeds the second; edges are taken from stages two and three.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            sync3_reg <= '0;
        end else begin
            sync1_reg <= event_in;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : gen_ch
            localparam bit SECOND = (g >= NUM_FIRST);
            wire sel = (wr_chan == g);
            wire wr_ctrl = reg_wr && sel && !wr_is_count;
            wire [1:0] code = reg_wdata[`TCRP_CTRL_MODE_MSB:`TCRP_CTRL_MODE_LSB];

            assign wr_count_sel[g] = reg_wr && sel && wr_is_count;

            // Second-group channels only run the timer mode here.
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    mode_reg[g] <= tcrp_pkg::TCRP_MODE_TIMER;
                    up_reg[g] <= 1'b0;
                    free_reg[g] <= 1'b0;
                end else if (wr_ctrl) begin
                    mode_reg[g] <= SECOND ? tcrp_pkg::TCRP_MODE_TIMER : decode_mode(code);
                    up_reg[g] <= reg_wdata[`TCRP_CTRL_UP_BIT] && !SECOND;
                    free_reg[g] <= reg_wdata[`TCRP_CTRL_FREE_BIT] && !SECOND;
                end
            end

            tcrp_channel u_ch (
                .clk(clk),
                .rst_n(rst_n),
                .start(start_reg[g]),
                .mode(mode_reg[g]),
                .count_up(up_reg[g]),
                .free_run(free_reg[g]),
                .wr_count(wr_count_sel[g]),
                .wr_data(reg_wdata),
                .event_pulse(sync2_reg[g] && !sync3_reg[g]),
                .count(count_w[g]),
                .reload_cycle(reload_cyc[g]),
                .pulse_out(pulse_w[g]),
                .irq_event(irq_evt[g])
            );
        end
    endgenerate

    // A new event wins over a write-one clear in the same cycle.
    always_comb begin
        status_next = status_reg;
        if (wr_status) begin
            status_next = status_reg & ~reg_wdata[NUM_CH-1:0];
        end
        status_next = status_next | irq_evt;
    end

    // reload-cycle reads see the wrapped value
    always_comb begin
        int rc;
        rc = chan_of(reg_addr);
        rdata_next = 16'h0000;
        if (reg_addr == `TCRP_ADDR_START) begin
            rdata_next[NUM_CH-1:0] = start_reg;
        end else if (reg_addr == `TCRP_ADDR_STATUS) begin
            rdata_next[NUM_CH-1:0] = status_reg;
        end else if (reg_addr == `TCRP_ADDR_MASK) begin
            rdata_next[NUM_CH-1:0] = mask_reg;
        end else if (rc >= 0) begin
            if (is_count_ofs(reg_addr)) begin
                rdata_next = count_w[rc];
            end else begin
                rdata_next[`TCRP_CTRL_MODE_MSB:`TCRP_CTRL_MODE_LSB] = encode_mode(mode_reg[rc]);
                rdata_next[`TCRP_CTRL_UP_BIT] = up_reg[rc];
                rdata_next[`TCRP_CTRL_FREE_BIT] = free_reg[rc];
                rdata_next[`TCRP_CTRL_RELOAD_BIT] = reload_cyc[rc];
                rdata_next[`TCRP_CTRL_PIN_BIT] = pulse_w[rc];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            start_reg <= '0;
            status_reg <= '0;
            mask_reg <= '0;
            rdata_reg <= 16'h0000;
            irq_reg <= 1'b0;
        end else begin
            if (wr_start) begin
                start_reg <= reg_wdata[NUM_CH-1:0];
            end
            if (wr_mask) begin
                mask_reg <= reg_wdata[NUM_CH-1:0];
            end
            status_reg <= status_next;
            rdata_reg <= reg_rd ? rdata_next : 16'h0000;
            irq_reg <= |(status_next & mask_reg);
        end
    end

    assign reg_rdata = rdata_reg;
    assign irq = irq_reg;
    assign pulse_output_pin = pulse_w;
endmodule
`default_nettype wire

//--- sim/tcrp_event_src.sv
`timescale 1ns/1ps
`default_nettype none
module tcrp_event_src (
    input wire logic clk,
    input wire logic [2:0] go,
    output logic [2:0] event_in
);
    int cnt = 0;
    logic [2:0] sel = 3'h0;
    // Three slow pulses per request, wide enough for the two-flop synchroniser.
    always @(posedge clk) begin
        if (go != 3'h0) begin
            sel <= go;
            cnt <= 24;
        end else if (cnt > 0)
            cnt <= cnt - 1;
        event_in <= (cnt > 0 && cnt % 8 >= 4) ? sel : 3'h0;
    end
endmodule
`default_nettype wire

//--- sim/tcrp_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module tcrp_monitor #(
    parameter int NUM_FIRST = 2,
    parameter int NUM_SECOND = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [5:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic [NUM_FIRST+NUM_SECOND-1:0] event_in,
    input wire logic [NUM_FIRST+NUM_SECOND-1:0] pulse_output_pin,
    input wire logic irq
);
    logic run_reg;
    logic held_reg;
    logic m0_reg;
    logic [15:0] val_reg;
    wire logic wr_start = reg_wr && reg_addr == 6'h20;
    wire logic wr_cnt0 = reg_wr && reg_addr == 6'h01;
    wire logic wr_mask = reg_wr && reg_addr == 6'h22;
    // A start write clears the shadow because a started counter no longer holds it.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            run_reg <= 1'b0;
            held_reg <= 1'b1;
            val_reg <= 16'hFFFF;
            m0_reg <= 1'b0;
        end else begin
            if (wr_start)
                run_reg <= reg_wdata[0];
            if (wr_start)
                held_reg <= 1'b0;
            if (wr_cnt0 && !run_reg)
                held_reg <= 1'b1;
            if (wr_cnt0 && !run_reg)
                val_reg <= reg_wdata;
            if (wr_mask)
                m0_reg <= reg_wdata[0];
        end
    end
    sequence stop_ch0;
        wr_start && !reg_wdata[0] && run_reg;
    endsequence
    sequence mask_cleared;
        wr_mask && reg_wdata == 16'h0000 ##1 !wr_mask;
    endsequence
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    rdata_idle_a: assert property (
        !reg_rd |=> reg_rdata == 16'h0000) else $error("read data not idle");
    held_read_a: assert property (
        reg_rd && reg_addr == 6'h01 && held_reg |=> reg_rdata == $past(val_reg))
        else $error("halted read differs");
    stop_high_a: assert property (
        stop_ch0 ##0 pulse_output_pin[0] |-> ##2 !pulse_output_pin[0] [*3])
        else $error("pin not low after stop");
    stop_flag_a: assert property (
        stop_ch0 ##0 (pulse_output_pin[0] && m0_reg) |-> ##[2:4] irq)
        else $error("no request after stop");
    stop_low_a: assert property (
        stop_ch0 ##0 !pulse_output_pin[0] |=> !pulse_output_pin[0] [*3])
        else $error("low pin changed on stop");
    mask_off_a: assert property (
        mask_cleared |=> !irq) else $error("masked request still high");
    unmapped_rd_a: assert property (
        reg_rd && reg_addr[5:4] == 2'h3 |=> reg_rdata == 16'h0000)
        else $error("unmapped read not zero");
    reset_out_a: assert property (
        $rose(rst_n) |-> !irq && pulse_output_pin == '0) else $error("outputs not reset");
endmodule
bind tcrp_top tcrp_monitor #(.NUM_FIRST(NUM_FIRST), .NUM_SECOND(NUM_SECOND)) tcrp_monitor_i (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .event_in(event_in),
    .pulse_output_pin(pulse_output_pin), .irq(irq));
`default_nettype wire

//--- sim/timer_counter_readback_pwm_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module timer_counter_readback_pwm_tb_top;
    typedef struct packed {
        logic [5:0] a;
        logic [15:0] c;
        logic [15:0] v;
        logic [15:0] e;
    } tcrp_row_t;
    tcrp_row_t rows [5] = '{'{6'h00, 16'h0000, 16'h0000, 16'h0000},
        '{6'h00, 16'h0005, 16'hFFFF, 16'h0005}, '{6'h00, 16'h0009, 16'h8000, 16'h0009},
        '{6'h04, 16'h0000, 16'h1234, 16'h0000}, '{6'h04, 16'h000D, 16'h0001, 16'h0000}};
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [5:0] reg_addr = 6'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [2:0] go = 3'h0;
    wire logic [15:0] reg_rdata;
    wire logic [2:0] event_in;
    wire logic [2:0] pins;
    wire logic irq;
    int n_fail = 0;
    int check_count = 0;
    tcrp_top tcrp_top_i (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .event_in(event_in),
        .pulse_output_pin(pins), .irq(irq));
    tcrp_event_src tcrp_event_src_i (.clk(clk), .go(go), .event_in(event_in));
    initial forever #2.5 clk = ~clk;
    task automatic stop_test();
        $display("mismatches %0d checks %0d", n_fail, check_count);
        if (n_fail == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        check_count++;
        if (s !== e) begin
            n_fail++;
            $display("mismatch at %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [15:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rc(input logic [5:0] a, input logic [15:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask
    task automatic wait_pin(input logic lv);
        int k;
        for (k = 0; k < 2000 && pins[0] !== lv; k++)
            @(posedge clk);
        if (k == 2000) begin
            n_fail++;
            stop_test();
        end
    endtask
    // Reads every cycle; in timer mode each value, in event mode each changed value, must follow from the one before it.
    task automatic walk(input int ch, input logic up, input logic tmr, input logic [15:0] r,
            input int n);
        logic [15:0] p, e, nv, edg, wrp;
        logic saw;
        int k;
        edg = up ? 16'hFFFF : 16'h0000;
        wrp = ~edg;
        saw = 1'b0;
        wr(6'(2 * ch), tmr ? 16'h0000 : {13'h0, up, 2'h1});
        wr(6'(2 * ch + 1), r);
        wr(6'h20, 16'(1 << ch));
        go <= tmr ? 3'h0 : 3'(1 << ch);
        repeat (2) @(posedge clk);
        go <= 3'h0;
        reg_addr <= 6'(2 * ch + 1);
        reg_rd <= 1'b1;
        for (k = 0; k < n; k++) begin
            @(posedge clk);
            if (k == n - 1)
                reg_rd <= 1'b0;
            #1 nv = reg_rdata;
            e = (p === edg) ? wrp : (p === wrp) ? r : up ? p + 16'h1 : p - 16'h1;
            if (k > 0 && (tmr || nv !== p))
                chk(nv, e);
            saw = saw | (nv === wrp);
            p = nv;
        end
        chk(16'(saw), 16'h0001);
        wr(6'h20, 16'h0000);
    endtask
    initial begin
        #200000;
        n_fail++;
        stop_test();
    end
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        rc(6'h01, 16'hFFFF);
        rc(6'h30, 16'h0000);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].c);
            wr(rows[i].a + 6'h1, rows[i].v);
            rc(rows[i].a + 6'h1, rows[i].v);
            rc(rows[i].a, rows[i].e);
        end
        walk(0, 1'b0, 1'b1, 16'h0005, 12);
        walk(2, 1'b0, 1'b1, 16'h0003, 10);
        walk(1, 1'b0, 1'b0, 16'h0002, 40);
        walk(1, 1'b1, 1'b0, 16'hFFFE, 40);
        // Free-run event counting: the value is set right after the start, and again after the stop.
        wr(6'h02, 16'h0009);
        wr(6'h20, 16'h0002);
        wr(6'h03, 16'h0001);
        go <= 3'h2;
        @(posedge clk);
        go <= 3'h0;
        repeat (40) @(posedge clk);
        rc(6'h03, 16'hFFFE);
        wr(6'h20, 16'h0000);
        wr(6'h03, 16'h0040);
        rc(6'h03, 16'h0040);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rc(6'h05, 16'hFFFF);
        // First pass enters pulse mode straight from reset, then from timer and event.
        for (int m = 0; m < 3; m++) begin
            if (m > 0)
                wr(6'h02, 16'(m - 1));
            wr(6'h21, 16'h0002);
            wr(6'h02, 16'h0002);
            // The request passes the channel's register first, so the status bit lands one edge late.
            @(posedge clk);
            rc(6'h21, 16'h0002);
            chk(16'(irq), 16'h0000);
        end
        wr(6'h22, 16'h0002);
        repeat (3) @(posedge clk);
        chk(16'(irq), 16'h0001);
        wr(6'h22, 16'h0000);
        wr(6'h21, 16'h0002);
        rc(6'h21, 16'h0000);
        wr(6'h22, 16'h0001);
        wr(6'h00, 16'h0002);
        wr(6'h01, 16'h0100);
        wr(6'h21, 16'h0001);
        wr(6'h20, 16'h0001);
        wait_pin(1'b1);
        wr(6'h20, 16'h0000);
        repeat (3) @(posedge clk);
        chk(16'(pins[0]), 16'h0000);
        chk(16'(irq), 16'h0001);
        rc(6'h21, 16'h0001);
        wr(6'h21, 16'h0001);
        wr(6'h20, 16'h0001);
        wait_pin(1'b1);
        wait_pin(1'b0);
        wr(6'h21, 16'h0001);
        wr(6'h20, 16'h0000);
        repeat (3) @(posedge clk);
        chk(16'(pins[0]), 16'h0000);
        rc(6'h21, 16'h0000);
        stop_test();
    end
endmodule
`default_nettype wire
